// [verilog/upr_pkg.sv]
// Shared constants and carrier types of the USB transceiver register block
package upr_pkg;

  // Register offsets (byte addresses on the peripheral port)
  localparam logic [7:0] OFS_IM_RESET    = 8'h00;
  localparam logic [7:0] OFS_OTG_CTRL    = 8'h10;
  localparam logic [7:0] OFS_OTG_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_SERIAL_CTRL = 8'h18;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_HOLD_SEL    = 8'h20;
  localparam logic [7:0] OFS_XCVR_CTRL   = 8'h40;

  // Field positions
  localparam int OTG_W         = 5;
  localparam int OTGF_W        = 6;
  localparam int SER_RX_LSB    = 4;
  localparam int SER_W         = 7;
  localparam int EVT_W         = 7;
  localparam int EV_TOKEN      = 6;
  localparam int EV_SE0        = 5;
  localparam int EV_K          = 4;
  localparam int EV_J          = 3;
  localparam int EV_CRC16      = 2;
  localparam int EV_RXACT      = 1;
  localparam int EV_RXERR      = 0;
  localparam int XC_PD_DIS     = 18;
  localparam int XC_WAKE_RESET = 13;
  localparam int XC_WAKE_K     = 12;
  localparam int XC_FILT_HI    = 11;
  localparam int XC_FILT_LO    = 8;
  localparam int XC_SUSP_EN    = 7;
  localparam int XC_CONF_HI    = 6;
  localparam int XC_CONF_LO    = 4;

  // Reset values
  localparam logic [4:0]  OTG_CTRL_RST = 5'h00;
  localparam logic [3:0]  SER_CTRL_RST = 4'h2;
  localparam logic [6:0]  HOLD_RST     = 7'h00;
  localparam logic [31:0] XCVR_RST     = 32'h0000_0000;

  // Line state encodings
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J   = 2'h1;
  localparam logic [1:0] LS_K   = 2'h2;

  // Line state filter counter width
  localparam int FILT_CNT_W = 16;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [31:0] data;
  } upr_req_type;

  typedef struct packed {
    logic        ack;
    logic        ok;
    logic [31:0] data;
  } upr_rsp_type;

  // Transceiver status levels: otg flags, rx levels, rx active/error
  typedef struct packed {
    logic [5:0] otg;
    logic [2:0] rxLevels;
    logic [1:0] lineState;
    logic       rxActive;
    logic       rxError;
  } upr_xcvr_in_type;

  typedef struct packed {
    logic       vbusChargeRequest;
    logic       vbusDischargeRequest;
    logic       dminusPulldownEnable;
    logic       dplusPulldownEnable;
    logic       idPinPullupEnable;
    logic       serialTxSingleEndedZero;
    logic       serialTxLevel;
    logic       serialTxEnableN;
    logic       fsLsSerialSelect;
    logic [2:0] transceiverConfigPins;
    logic       padPulldownDisable;
  } upr_xcvr_out_type;

endpackage

// [verilog/upr_usb_phy_regs.sv]
// Configuration and status registers of the USB interface manager
// How it works
// - Otg bits 4,3 charge/discharge VBUS, reset 0
// - Otg bits 2,1 enable D-minus/D-plus pulldowns
// - Otg bit 0 enables ID line pullup
// - Otg flags mirror live transceiver session status
// - Serial bits 6:4 report receive line levels
// - Serial bit 3 forces SE0, bit 2 data
// - Serial bit 1 active-low transmit enable, resets 1
// - Serial bit 0 selects serial FS/LS mode
// - Event flags clear on packet start unless held
// - Event bit 6 on valid token to us
// - Event bits 5,4,3 on SE0, K, J
// - Event bit 2 on data CRC16 failure
// - Event bits 1,0 follow rx active/error unless held
// - Held flags clear only by writing one or by a manager reset
// - Transceiver bit 18 disables pad pulldowns
// - Bit 13 flags wake by bus reset
// - Bit 12 flags wake by resume K
// - Bits 11:8 log2 line state filter length
// - Bit 7 hands resume to hardware suspend logic
// - Bits 6:4 drive transceiver config pins
// - Any write at offset 0 resets manager state
`timescale 1ns/10ps
module upr_usb_phy_regs (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire upr_pkg::upr_req_type      regReq,
  output upr_pkg::upr_rsp_type           regRsp,
  input  wire upr_pkg::upr_xcvr_in_type  xcvrIn,
  input  wire logic                      packetStart,
  input  wire logic                      tokenGood,
  input  wire logic [6:0]                tokenAddr,
  input  wire logic [6:0]                deviceAddr,
  input  wire logic                      crc16Fail,
  input  wire logic                      suspended,
  output upr_pkg::upr_xcvr_out_type      xcvrOut,
  output logic [1:0]                     filteredLineState,
  output logic                           managerReset
);

  upr_pkg::upr_xcvr_in_type syncA_q;
  upr_pkg::upr_xcvr_in_type syncB_q;
  logic [4:0]  otgCtrl_q;
  logic [3:0]  serCtrl_q;
  logic [6:0]  evtFlags_q;
  logic [6:0]  holdSel_q;
  logic [3:0]  filtLog_q;
  logic        suspEn_q;
  logic        wakeReset_q;
  logic        wakeK_q;
  logic [1:0]  lsPrev_q;
  logic [upr_pkg::FILT_CNT_W-1:0] stableCnt_q;
  logic [upr_pkg::FILT_CNT_W-1:0] filtTarget;
  logic        wrAcc;
  logic        rdAcc;
  logic        hit;
  logic        softRst;
  logic [6:0]  evtSet;
  logic [6:0]  evtClr;
  logic        filtUpdate;
  logic [31:0] rdData;

  function automatic logic isWr(input upr_pkg::upr_req_type r,
                                input logic [7:0] ofs);
    return r.write && r.addr == ofs;
  endfunction

  // Decode: the reset register is write-only, otg flags read-only
  always_comb begin
    hit = 1'b1;
    rdData = 32'h0000_0000;
    case (regReq.addr)
      upr_pkg::OFS_IM_RESET:    hit = regReq.write;
      upr_pkg::OFS_OTG_CTRL:    rdData = {27'h0, otgCtrl_q};
      upr_pkg::OFS_OTG_FLAGS: begin
        hit = regReq.read;
        rdData = {26'h0, syncB_q.otg};
      end
      upr_pkg::OFS_SERIAL_CTRL:
        rdData = {25'h0, syncB_q.rxLevels, serCtrl_q};
      upr_pkg::OFS_EVENT_FLAGS: rdData = {25'h0, evtFlags_q};
      upr_pkg::OFS_HOLD_SEL:    rdData = {25'h0, holdSel_q};
      upr_pkg::OFS_XCVR_CTRL: begin
        rdData = 32'h0000_0000;
        rdData[upr_pkg::XC_PD_DIS] = xcvrOut.padPulldownDisable;
        rdData[upr_pkg::XC_WAKE_RESET] = wakeReset_q;
        rdData[upr_pkg::XC_WAKE_K] = wakeK_q;
        rdData[upr_pkg::XC_FILT_HI:upr_pkg::XC_FILT_LO] = filtLog_q;
        rdData[upr_pkg::XC_SUSP_EN] = suspEn_q;
        rdData[upr_pkg::XC_CONF_HI:upr_pkg::XC_CONF_LO] =
          xcvrOut.transceiverConfigPins;
      end
      default: hit = 1'b0;
    endcase
  end

  assign wrAcc = regReq.write && hit;
  assign rdAcc = regReq.read && !regReq.write && hit;
  assign softRst = isWr(regReq, upr_pkg::OFS_IM_RESET);

  // One-cycle answer; unmapped or wrong-direction accesses fail
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRsp <= '0;
    end else begin
      regRsp.ack <= regReq.write || regReq.read;
      regRsp.ok <= wrAcc || rdAcc;
      regRsp.data <= rdAcc ? rdData : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      managerReset <= 1'b0;
    end else begin
      managerReset <= softRst;
    end
  end

  // Two-stage synchroniser on every transceiver status level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= xcvrIn;
      syncB_q <= syncA_q;
    end
  end

  // Transceiver-facing controls survive a manager reset on purpose
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      otgCtrl_q <= upr_pkg::OTG_CTRL_RST;
      serCtrl_q <= upr_pkg::SER_CTRL_RST;
    end else begin
      if (isWr(regReq, upr_pkg::OFS_OTG_CTRL)) begin
        otgCtrl_q <= regReq.data[upr_pkg::OTG_W-1:0];
      end
      if (isWr(regReq, upr_pkg::OFS_SERIAL_CTRL)) begin
        serCtrl_q <= regReq.data[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xcvrOut <= '0;
      xcvrOut.serialTxEnableN <= 1'b1;
    end else begin
      xcvrOut.vbusChargeRequest <= otgCtrl_q[4];
      xcvrOut.vbusDischargeRequest <= otgCtrl_q[3];
      xcvrOut.dminusPulldownEnable <= otgCtrl_q[2];
      xcvrOut.dplusPulldownEnable <= otgCtrl_q[1];
      xcvrOut.idPinPullupEnable <= otgCtrl_q[0];
      xcvrOut.serialTxSingleEndedZero <= serCtrl_q[3];
      xcvrOut.serialTxLevel <= serCtrl_q[2];
      xcvrOut.serialTxEnableN <= serCtrl_q[1];
      xcvrOut.fsLsSerialSelect <= serCtrl_q[0];
      if (isWr(regReq, upr_pkg::OFS_XCVR_CTRL)) begin
        xcvrOut.padPulldownDisable <=
          regReq.data[upr_pkg::XC_PD_DIS];
        xcvrOut.transceiverConfigPins <=
          regReq.data[upr_pkg::XC_CONF_HI:upr_pkg::XC_CONF_LO];
      end
    end
  end

  // Line state filter: a new level must hold 2**N samples
  assign filtTarget = upr_pkg::FILT_CNT_W'(1) << filtLog_q;
  assign filtUpdate = syncB_q.lineState == lsPrev_q &&
                      stableCnt_q >= filtTarget &&
                      filteredLineState != lsPrev_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lsPrev_q <= upr_pkg::LS_J;
      stableCnt_q <= '0;
      filteredLineState <= upr_pkg::LS_J;
    end else if (softRst) begin
      lsPrev_q <= syncB_q.lineState;
      stableCnt_q <= upr_pkg::FILT_CNT_W'(1);
      filteredLineState <= upr_pkg::LS_J;
    end else begin
      lsPrev_q <= syncB_q.lineState;
      if (syncB_q.lineState != lsPrev_q) begin
        stableCnt_q <= upr_pkg::FILT_CNT_W'(1);
      end else if (stableCnt_q != '1) begin
        stableCnt_q <= stableCnt_q + upr_pkg::FILT_CNT_W'(1);
      end
      if (filtUpdate) begin
        filteredLineState <= lsPrev_q;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      filtLog_q <= upr_pkg::XCVR_RST[upr_pkg::XC_FILT_HI:upr_pkg::XC_FILT_LO];
      suspEn_q <= 1'b0;
    end else if (isWr(regReq, upr_pkg::OFS_XCVR_CTRL)) begin
      filtLog_q <= regReq.data[upr_pkg::XC_FILT_HI:upr_pkg::XC_FILT_LO];
      suspEn_q <= regReq.data[upr_pkg::XC_SUSP_EN];
    end
  end

  // Wake cause: only when the hardware suspend logic owns resume
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wakeReset_q <= 1'b0;
      wakeK_q <= 1'b0;
    end else if (softRst) begin
      wakeReset_q <= 1'b0;
      wakeK_q <= 1'b0;
    end else begin
      if (suspEn_q && suspended && filtUpdate &&
          lsPrev_q == upr_pkg::LS_SE0) begin
        wakeReset_q <= 1'b1;
      end else if (isWr(regReq, upr_pkg::OFS_XCVR_CTRL) &&
                   !regReq.data[upr_pkg::XC_WAKE_RESET]) begin
        wakeReset_q <= 1'b0;
      end
      if (suspEn_q && suspended && filtUpdate &&
          lsPrev_q == upr_pkg::LS_K) begin
        wakeK_q <= 1'b1;
      end else if (isWr(regReq, upr_pkg::OFS_XCVR_CTRL) &&
                   !regReq.data[upr_pkg::XC_WAKE_K]) begin
        wakeK_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      holdSel_q <= upr_pkg::HOLD_RST;
    end else if (isWr(regReq, upr_pkg::OFS_HOLD_SEL)) begin
      holdSel_q <= regReq.data[upr_pkg::EVT_W-1:0];
    end
  end

  always_comb begin
    evtSet = '0;
    evtSet[upr_pkg::EV_TOKEN] = tokenGood && tokenAddr == deviceAddr;
    evtSet[upr_pkg::EV_SE0] = filteredLineState == upr_pkg::LS_SE0;
    evtSet[upr_pkg::EV_K] = filteredLineState == upr_pkg::LS_K;
    evtSet[upr_pkg::EV_J] = filteredLineState == upr_pkg::LS_J;
    evtSet[upr_pkg::EV_CRC16] = crc16Fail;
    evtSet[upr_pkg::EV_RXACT] = syncB_q.rxActive;
    evtSet[upr_pkg::EV_RXERR] = syncB_q.rxError;
    evtClr = isWr(regReq, upr_pkg::OFS_EVENT_FLAGS) ?
             regReq.data[upr_pkg::EVT_W-1:0] : 7'h00;
  end

  // A set wins over a write-one or packet-start clear in the same cycle; a manager reset wins over a set
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evtFlags_q <= '0;
    end else if (softRst) begin
      evtFlags_q <= '0;
    end else begin
      for (int i = 0; i < upr_pkg::EVT_W; i++) begin
        if (evtSet[i]) begin
          evtFlags_q[i] <= 1'b1;
        end else if (i <= upr_pkg::EV_RXACT && !holdSel_q[i]) begin
          evtFlags_q[i] <= 1'b0;
        end else if (evtClr[i]) begin
          evtFlags_q[i] <= 1'b0;
        end else if (packetStart && !holdSel_q[i]) begin
          evtFlags_q[i] <= 1'b0;
        end
      end
    end
  end

  sequence s_otgWrite;
    isWr(regReq, upr_pkg::OFS_OTG_CTRL);
  endsequence

  property p_otg_drive;
    @(posedge ref_clk) disable iff (rst)
    s_otgWrite |-> ##2
      ({xcvrOut.vbusChargeRequest, xcvrOut.vbusDischargeRequest,
        xcvrOut.dminusPulldownEnable, xcvrOut.dplusPulldownEnable,
        xcvrOut.idPinPullupEnable} == $past(regReq.data[4:0], 2));
  endproperty
  a_otg_drive: assert property (p_otg_drive)
    else $error("otg control pins do not follow write");

  property p_serial_drive;
    @(posedge ref_clk) disable iff (rst)
    isWr(regReq, upr_pkg::OFS_SERIAL_CTRL) |-> ##2
      xcvrOut.serialTxEnableN == $past(regReq.data[1], 2) &&
      xcvrOut.fsLsSerialSelect == $past(regReq.data[0], 2);
  endproperty
  a_serial_drive: assert property (p_serial_drive)
    else $error("serial control pins do not follow write");

  property p_config_pins;
    @(posedge ref_clk) disable iff (rst)
    isWr(regReq, upr_pkg::OFS_XCVR_CTRL) |=>
      xcvrOut.transceiverConfigPins == $past(regReq.data[6:4]);
  endproperty
  a_config_pins: assert property (p_config_pins)
    else $error("config pins do not follow write");

  property p_held_flag;
    @(posedge ref_clk) disable iff (rst)
    holdSel_q[upr_pkg::EV_TOKEN] && evtFlags_q[upr_pkg::EV_TOKEN] &&
    !evtClr[upr_pkg::EV_TOKEN] && !softRst |=>
      evtFlags_q[upr_pkg::EV_TOKEN];
  endproperty
  a_held_flag: assert property (p_held_flag)
    else $error("held flag lost without a clear");

  property p_packet_clear;
    @(posedge ref_clk) disable iff (rst)
    packetStart && !holdSel_q[upr_pkg::EV_CRC16] && !crc16Fail |=>
      !evtFlags_q[upr_pkg::EV_CRC16];
  endproperty
  a_packet_clear: assert property (p_packet_clear)
    else $error("unheld flag survived packet start");

  property p_token_set;
    @(posedge ref_clk) disable iff (rst)
    tokenGood && tokenAddr == deviceAddr && !softRst |=>
      evtFlags_q[upr_pkg::EV_TOKEN];
  endproperty
  a_token_set: assert property (p_token_set)
    else $error("matching token not flagged");

  property p_rx_follow;
    @(posedge ref_clk) disable iff (rst)
    !holdSel_q[upr_pkg::EV_RXACT] && !softRst |=>
      evtFlags_q[upr_pkg::EV_RXACT] == $past(syncB_q.rxActive);
  endproperty
  a_rx_follow: assert property (p_rx_follow)
    else $error("rx active flag does not follow input");

  property p_filter_stable;
    @(posedge ref_clk) disable iff (rst)
    !softRst ##1 $changed(filteredLineState) |->
      $past(stableCnt_q) >= $past(filtTarget);
  endproperty
  a_filter_stable: assert property (p_filter_stable)
    else $error("line state passed filter too early");

  property p_wake_reset;
    @(posedge ref_clk) disable iff (rst)
    suspEn_q && suspended && filtUpdate &&
    lsPrev_q == upr_pkg::LS_SE0 && !softRst |=> wakeReset_q;
  endproperty
  a_wake_reset: assert property (p_wake_reset)
    else $error("wake by reset not recorded");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (rst)
    rdAcc && regReq.addr == upr_pkg::OFS_OTG_FLAGS |=>
      regRsp.ack && regRsp.ok && regRsp.data[31:6] == 26'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

endmodule

// [testbench/upr_xcvr_model.sv]
// Behavioural transceiver front end facing the register block
`timescale 1ns/10ps
module upr_xcvr_model (
  input  wire upr_pkg::upr_xcvr_out_type xcvrOut,
  input  wire logic [5:0]                otgLevels,
  input  wire logic [1:0]                busLine,
  input  wire logic                      rxAct,
  input  wire logic                      rxErr,
  output upr_pkg::upr_xcvr_in_type       xcvrIn
);
  logic [1:0] ls;
  logic       txOn;

  // Own drive wins over the far bus only in serial mode with enable low
  assign txOn = xcvrOut.fsLsSerialSelect & ~xcvrOut.serialTxEnableN;

  always_comb begin
    ls = busLine;
    if (txOn) begin
      if (xcvrOut.serialTxSingleEndedZero)
        ls = upr_pkg::LS_SE0;
      else
        ls = xcvrOut.serialTxLevel ? upr_pkg::LS_J : upr_pkg::LS_K;
    end
    xcvrIn.otg       = otgLevels;
    xcvrIn.rxActive  = rxAct;
    xcvrIn.rxError   = rxErr;
    xcvrIn.lineState = ls;
    // Receivers report differential, D-minus, D-plus of the settled line
    xcvrIn.rxLevels  = (ls == upr_pkg::LS_J) ? 3'h5 :
                       (ls == upr_pkg::LS_K) ? 3'h2 : 3'h0;
  end
endmodule

// [testbench/tb_top.sv]
// Register access testbench of the USB transceiver register block
`timescale 1ns/10ps
module tb_top;
  logic                      ref_clk;
  logic                      rst;
  upr_pkg::upr_req_type      req;
  upr_pkg::upr_rsp_type      rsp;
  upr_pkg::upr_xcvr_in_type  xin;
  upr_pkg::upr_xcvr_out_type xout;
  logic                      packetStart;
  logic                      tokenGood;
  logic                      crc16Fail;
  logic                      suspended;
  logic [6:0]                tokenAddr;
  logic [6:0]                deviceAddr;
  logic [1:0]                filtLs;
  logic                      mgrRst;
  logic [5:0]                otgLv;
  logic [1:0]                busLn;
  logic                      rxAct;
  logic                      rxErr;
  logic                      rOk;
  logic [31:0]               rData;
  int                        mismatches;
  int                        checksDone;
  int                        mrCnt;

  upr_usb_phy_regs dut_u (.ref_clk(ref_clk), .rst(rst), .regReq(req),
    .regRsp(rsp), .xcvrIn(xin), .packetStart(packetStart),
    .tokenGood(tokenGood), .tokenAddr(tokenAddr), .deviceAddr(deviceAddr),
    .crc16Fail(crc16Fail), .suspended(suspended), .xcvrOut(xout),
    .filteredLineState(filtLs), .managerReset(mgrRst));

  upr_xcvr_model xcvr_u (.xcvrOut(xout), .otgLevels(otgLv), .busLine(busLn),
    .rxAct(rxAct), .rxErr(rxErr), .xcvrIn(xin));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Counted away from the launching edge so the pulse is seen settled
  always @(negedge ref_clk) begin
    if (mgrRst === 1'b1)
      mrCnt++;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One request per call; answer is awaited under a short bound
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    req.write = wr;
    req.read  = ~wr;
    req.addr  = a;
    req.data  = d;
    @(negedge ref_clk);
    req.write = 1'b0;
    req.read  = 1'b0;
    while (rsp.ack !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    rOk   = rsp.ok;
    rData = rsp.data;
    check("ack", 32'(n < 4), 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    access(1'b1, a, d);
    check("write ok", 32'(rOk), 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, exp);
    access(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rData & m, exp);
  endtask

  task automatic ev(input logic [2:0] k);
    @(negedge ref_clk);
    {packetStart, tokenGood, crc16Fail} = k;
    @(negedge ref_clk);
    {packetStart, tokenGood, crc16Fail} = 3'h0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] pat [3];
    logic [31:0] ser [3];
    logic [31:0] serRd [3];
    pat   = '{32'hffff_ffff, 32'h0000_000a, 32'h0000_0015};
    ser   = '{32'h0000_000d, 32'h0000_0005, 32'h0000_0001};
    serRd = '{32'h0000_000d, 32'h0000_0055, 32'h0000_0021};
    req = '0;
    {packetStart, tokenGood, crc16Fail, suspended, rxAct, rxErr} = '0;
    tokenAddr = 7'h2d;
    deviceAddr = 7'h2d;
    otgLv = 6'h00;
    busLn = upr_pkg::LS_J;
    mismatches = 0;
    checksDone = 0;
    mrCnt = 0;
    rst = 1'b1;
    idle(5);
    rst = 1'b0;
    rd(upr_pkg::OFS_OTG_CTRL, 32'hffff_ffff, 32'h0);
    rd(upr_pkg::OFS_OTG_FLAGS, 32'hffff_ffff, 32'h0);
    rd(upr_pkg::OFS_SERIAL_CTRL, 32'hffff_ffff, 32'h52);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'hffff_ffc7, 32'h0);
    rd(upr_pkg::OFS_HOLD_SEL, 32'hffff_ffff, 32'h0);
    rd(upr_pkg::OFS_XCVR_CTRL, 32'hffff_ffff, 32'h0);
    check("txEnableN", 32'(xout.serialTxEnableN), 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(upr_pkg::OFS_OTG_CTRL, pat[i]);
      idle(2);
      rd(upr_pkg::OFS_OTG_CTRL, 32'hffff_ffff, pat[i] & 32'h1f);
      check("otg pins", 32'({xout.vbusChargeRequest,
        xout.vbusDischargeRequest, xout.dminusPulldownEnable,
        xout.dplusPulldownEnable, xout.idPinPullupEnable}),
        pat[i] & 32'h1f);
    end
    otgLv = 6'h2a;
    idle(3);
    rd(upr_pkg::OFS_OTG_FLAGS, 32'hffff_ffff, 32'h2a);
    otgLv = 6'h15;
    idle(3);
    rd(upr_pkg::OFS_OTG_FLAGS, 32'hffff_ffff, 32'h15);
    access(1'b1, upr_pkg::OFS_OTG_FLAGS, 32'hff);
    check("ro write ok", 32'(rOk), 32'h0);
    rd(upr_pkg::OFS_OTG_FLAGS, 32'hffff_ffff, 32'h15);
    for (int i = 0; i < 3; i++) begin
      wr(upr_pkg::OFS_SERIAL_CTRL, ser[i]);
      idle(5);
      rd(upr_pkg::OFS_SERIAL_CTRL, 32'hffff_ffff, serRd[i]);
    end
    wr(upr_pkg::OFS_SERIAL_CTRL, 32'hffff_ffff);
    idle(5);
    rd(upr_pkg::OFS_SERIAL_CTRL, 32'hffff_ffff, 32'h5f);
    wr(upr_pkg::OFS_SERIAL_CTRL, 32'h2);
    wr(upr_pkg::OFS_EVENT_FLAGS, 32'h7f);
    ev(3'h3);
    idle(2);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h44, 32'h44);
    ev(3'h4);
    idle(2);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h44, 32'h0);
    tokenAddr = 7'h2c;
    ev(3'h2);
    idle(2);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h40, 32'h0);
    rxAct = 1'b1;
    idle(4);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h2, 32'h2);
    rxAct = 1'b0;
    idle(4);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h2, 32'h0);
    wr(upr_pkg::OFS_HOLD_SEL, 32'hffff_ffff);
    rd(upr_pkg::OFS_HOLD_SEL, 32'hffff_ffff, 32'h7f);
    rxErr = 1'b1;
    tokenAddr = 7'h2d;
    idle(4);
    rxErr = 1'b0;
    ev(3'h2);
    ev(3'h4);
    idle(4);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h41, 32'h41);
    wr(upr_pkg::OFS_EVENT_FLAGS, 32'h41);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h41, 32'h0);
    wr(upr_pkg::OFS_HOLD_SEL, 32'h0);
    busLn = upr_pkg::LS_K;
    idle(6);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h10, 32'h10);
    busLn = upr_pkg::LS_SE0;
    idle(6);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h20, 32'h20);
    busLn = upr_pkg::LS_J;
    idle(6);
    rd(upr_pkg::OFS_EVENT_FLAGS, 32'h08, 32'h08);
    wr(upr_pkg::OFS_XCVR_CTRL, 32'hffff_ffff);
    check("pad pd off", 32'(xout.padPulldownDisable), 32'h1);
    check("conf pins", 32'(xout.transceiverConfigPins), 32'h7);
    rd(upr_pkg::OFS_XCVR_CTRL, 32'hffff_ffff, 32'h0004_0ff0);
    wr(upr_pkg::OFS_XCVR_CTRL, 32'h0004_03f0);
    busLn = upr_pkg::LS_K;
    idle(3);
    busLn = upr_pkg::LS_J;
    idle(20);
    check("glitch", 32'(filtLs), 32'(upr_pkg::LS_J));
    busLn = upr_pkg::LS_K;
    idle(6);
    check("too early", 32'(filtLs), 32'(upr_pkg::LS_J));
    idle(10);
    check("filtered", 32'(filtLs), 32'(upr_pkg::LS_K));
    busLn = upr_pkg::LS_J;
    suspended = 1'b1;
    idle(20);
    busLn = upr_pkg::LS_SE0;
    idle(20);
    rd(upr_pkg::OFS_XCVR_CTRL, 32'h3000, 32'h2000);
    busLn = upr_pkg::LS_K;
    idle(20);
    rd(upr_pkg::OFS_XCVR_CTRL, 32'h3000, 32'h3000);
    wr(upr_pkg::OFS_XCVR_CTRL, 32'h0004_03f0);
    rd(upr_pkg::OFS_XCVR_CTRL, 32'h3000, 32'h0);
    wr(upr_pkg::OFS_XCVR_CTRL, 32'h0000_0300);
    busLn = upr_pkg::LS_SE0;
    idle(20);
    rd(upr_pkg::OFS_XCVR_CTRL, 32'h3000, 32'h0);
    suspended = 1'b0;
    busLn = upr_pkg::LS_J;
    check("no soft reset", 32'(mrCnt), 32'h0);
    wr(upr_pkg::OFS_IM_RESET, 32'h1234);
    idle(3);
    check("soft reset", 32'(mrCnt), 32'h1);
    rd(upr_pkg::OFS_XCVR_CTRL, 32'hffff_ffff, 32'h300);
    access(1'b0, upr_pkg::OFS_IM_RESET, 32'h0);
    check("wo read ok", 32'(rOk), 32'h0);
    access(1'b0, 8'h44, 32'h0);
    check("unmapped ok", 32'(rOk), 32'h0);
    check("unmapped data", rData, 32'h0);
    tally_and_finish();
  end
endmodule
